// >>> rtl/byte_fold.sv
/*
 * one-byte fold of the running checksum, registered.
 * assumes: caller holds load/step exclusive per cycle; seed loading wins.
 */
`timescale 1ns/1ps
module byte_fold (
    input  wire logic        clock,     // system clock
    input  wire logic        srst,      // sync reset, active high
    input  wire logic        load,      // load seed
    input  wire logic [15:0] seed,      // seed value
    input  wire logic        step,      // fold one byte
    input  wire logic [7:0]  data,      // byte to fold
    input  wire logic        reverse,   // bit-reverse the byte first
    output logic      [15:0] result_r   // running checksum
);
    logic [15:0] result_nxt;

    // reverse within the byte when asked
    function automatic logic [7:0] flip8(input logic [7:0] b);
        for (int i = 0; i < checksum_unit_pkg::BYTE_W; i++) begin
            flip8[i] = b[checksum_unit_pkg::BYTE_W-1-i];
        end
    endfunction

    // msb-first shift of eight bits, all in one cycle
    always_comb begin
        logic [7:0] b;
        b          = reverse ? flip8(data) : data;
        result_nxt = result_r ^ {b, 8'h00};
        for (int k = 0; k < checksum_unit_pkg::BYTE_W; k++) begin
            result_nxt = result_nxt[15] ? ((result_nxt << 1) ^ checksum_unit_pkg::POLY)
                                        : (result_nxt << 1);
        end
    end

    // whole byte finishes before the next is taken
    always_ff @(posedge clock) begin
        if (srst) begin
            result_r <= checksum_unit_pkg::SEED_ZEROS;
        end else if (load) begin
            result_r <= seed;
        end else if (step) begin
            result_r <= result_nxt;
        end
    end
endmodule

// >>> rtl/checksum_unit.sv
/*
 * checksum unit: crc-16 over a byte stream from the core or over whole
 * 256-byte flash blocks read autonomously.
 *
 * core path: a byte is taken on any edge with in_valid and in_ready high
 * and is folded into result by that same edge; bytes may come back to back.
 * init loads the selected seed and wins over a core byte in the same cycle.
 * a scan start never loads the seed, so software issues init first.
 * reverse flips the bit order of core and flash bytes alike.
 * the crc is not reflected and has no final xor.
 *
 * scan path: auto_start in idle latches start_block and block_count; each
 * byte then costs one request cycle plus however long the flash takes.
 * addresses rise from start_block * 256 to the last byte of the last block,
 * and done pulses for one cycle after the final byte has been folded.
 * the block number wraps from the top block back to block zero.
 * a flash strobe that arrives outside a wait is ignored.
 *
 * limitation: a running scan cannot be stopped; init and core bytes are
 * refused until done, so software waits for busy to fall.
 * trade-off: all eight bit steps of a byte run in one cycle, a longer
 * combinational path in exchange for a byte on every clock.
 * after reset result reads zero, the same as the all-zero seed.
 *
 * assumes: flash returns rd_valid some cycles after one rd_req pulse,
 * one request outstanding, with rd_data valid in the rd_valid cycle.
 * assumes: all inputs synchronous to clock; srst is synchronous too.
 */
// Contract
// - fold bytes with polynomial 0x1021
// - take byte-wide inputs, one per fold
// - keep 16-bit result in internal register
// - seed selectable, all zeros or ones
// - automatic crc over 256-byte flash blocks
`timescale 1ns/1ps
module checksum_unit (
    input  wire logic        clock,       // system clock, 25 MHz
    input  wire logic        srst,        // sync reset, active high
    input  wire logic        init,        // pulse: load the seed
    input  wire logic        seed_ones,   // 1 selects all-ones seed
    input  wire logic        reverse,     // bit-reverse each byte
    input  wire logic        in_valid,    // core byte strobe
    input  wire logic [7:0]  in_data,     // core byte
    output logic             in_ready,    // core may feed
    input  wire logic        auto_start,  // pulse: begin flash scan
    input  wire logic [7:0]  start_block, // first 256-byte block
    input  wire logic [7:0]  block_count, // blocks minus one
    output logic             rd_req,      // flash read request
    output logic      [15:0] rd_addr,     // flash byte address
    input  wire logic        rd_valid,    // flash data ready
    input  wire logic [7:0]  rd_data,     // flash byte
    output logic             busy,        // scan in progress
    output logic             done,        // scan finished pulse
    output logic      [15:0] result       // running checksum
);
    // sequencer state and scan position
    checksum_unit_pkg::scan_state_t state_r;    // one-hot scan state
    logic [7:0]                     blk_r;      // current flash block
    logic [7:0]                     left_r;     // blocks left after this one
    logic [7:0]                     off_r;      // byte offset inside the block

    // one-hot decodes
    logic                           is_idle;    // no scan running
    logic                           is_req;     // request cycle
    logic                           is_wait;    // waiting on flash
    logic                           is_done;    // scan just ended

    // strobes and scan position flags
    logic                           scan_start; // scan accepted this cycle
    logic                           flash_take; // flash byte accepted
    logic                           core_take;  // core byte accepted
    logic                           seed_load;  // seed goes into the fold
    logic [15:0]                    seed_val;   // selected seed
    logic                           blk_end;    // offset at the top of a block
    logic                           last_byte;  // final byte of final block

    // fold inputs
    logic                           step;       // fold one byte this cycle
    logic [7:0]                     fold_data;  // byte handed to the fold

    // state decode, used by every strobe below
    function automatic logic in_state(
        input checksum_unit_pkg::scan_state_t cur,
        input checksum_unit_pkg::scan_state_t want
    );
        in_state = (cur == want);
    endfunction

    // shared by offset and block stepping; both wrap at 8 bits on purpose
    function automatic logic [7:0] bump(input logic [7:0] v);
        bump = v + 8'h01;
    endfunction

    // seed choice: only the all-zero and all-one values exist
    function automatic logic [15:0] pick_seed(input logic ones);
        pick_seed = ones ? checksum_unit_pkg::SEED_ONES : checksum_unit_pkg::SEED_ZEROS;
    endfunction

    // one-hot state decode
    assign is_idle = in_state(state_r, checksum_unit_pkg::ST_IDLE);
    assign is_req  = in_state(state_r, checksum_unit_pkg::ST_REQ);
    assign is_wait = in_state(state_r, checksum_unit_pkg::ST_WAIT);
    assign is_done = in_state(state_r, checksum_unit_pkg::ST_DONE);

    // acceptance strobes; init always wins over a start or a core byte
    assign scan_start = is_idle && auto_start && !init;
    assign flash_take = is_wait && rd_valid;
    assign core_take  = in_valid && in_ready;
    assign seed_load  = init && !busy;
    assign seed_val   = pick_seed(seed_ones);

    // scan position: a block turns over after offset 0xff
    assign blk_end   = (off_r == checksum_unit_pkg::BLK_LAST);
    assign last_byte = blk_end && (left_r == checksum_unit_pkg::BLK_ZERO);

    // core feeding is locked out while the scan owns the engine
    assign in_ready = is_idle && !init;

    // status and flash request straight from the state
    assign busy     = !is_idle;
    assign done     = is_done;
    assign rd_req   = is_req;
    assign rd_addr  = {blk_r, off_r};

    // one source at a time feeds the fold; a stray flash strobe outside
    // a wait is dropped, never folded
    always_comb begin
        step      = 1'b0;
        fold_data = in_data;
        case (state_r)
            checksum_unit_pkg::ST_IDLE: begin
                step      = core_take;
                fold_data = in_data;
            end
            checksum_unit_pkg::ST_WAIT: begin
                step      = flash_take;
                fold_data = rd_data;
            end
            default: begin
                step      = 1'b0;
                fold_data = in_data;
            end
        endcase
    end

    // the fold owns the result register
    byte_fold u_fold (
        .clock    (clock),
        .srst     (srst),
        .load     (seed_load),
        .seed     (seed_val),
        .step     (step),
        .data     (fold_data),
        .reverse  (reverse),
        .result_r (result)
    );

    // scan sequencer: request, wait, advance through each block
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= checksum_unit_pkg::ST_IDLE;
        end else begin
            case (state_r)
                checksum_unit_pkg::ST_IDLE: begin
                    if (scan_start) begin
                        state_r <= checksum_unit_pkg::ST_REQ;
                    end
                end
                checksum_unit_pkg::ST_REQ: begin
                    state_r <= checksum_unit_pkg::ST_WAIT;
                end
                checksum_unit_pkg::ST_WAIT: begin
                    if (flash_take && last_byte) begin
                        state_r <= checksum_unit_pkg::ST_DONE;
                    end else if (flash_take) begin
                        state_r <= checksum_unit_pkg::ST_REQ;
                    end
                end
                checksum_unit_pkg::ST_DONE: begin
                    state_r <= checksum_unit_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= checksum_unit_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // block number: latched at start, stepped as each block but the last completes
    always_ff @(posedge clock) begin
        if (srst) begin
            blk_r <= checksum_unit_pkg::BLK_ZERO;
        end else if (scan_start) begin
            blk_r <= start_block;
        end else if (flash_take && blk_end && !last_byte) begin
            blk_r <= bump(blk_r);
        end
    end

    // blocks still to go; zero marks the final block
    always_ff @(posedge clock) begin
        if (srst) begin
            left_r <= checksum_unit_pkg::BLK_ZERO;
        end else if (scan_start) begin
            left_r <= block_count;
        end else if (flash_take && blk_end && !last_byte) begin
            left_r <= left_r - 8'h01;
        end
    end

    // byte offset: one step per folded flash byte except the final one, wrapping at 256
    always_ff @(posedge clock) begin
        if (srst) begin
            off_r <= checksum_unit_pkg::BLK_ZERO;
        end else if (scan_start) begin
            off_r <= checksum_unit_pkg::BLK_ZERO;
        end else if (flash_take && !last_byte) begin
            off_r <= bump(off_r);
        end
    end
endmodule

// >>> rtl/checksum_unit_pkg.sv
/*
 * constants shared by the checksum unit: polynomial, seeds, block size,
 * flash address width and the automatic-scan states.
 * assumes: nothing beyond a systemverilog compiler.
 */
package checksum_unit_pkg;
    localparam logic [15:0] POLY          = 16'h1021;
    localparam logic [15:0] SEED_ZEROS    = 16'h0000;
    localparam logic [15:0] SEED_ONES     = 16'hffff;
    localparam int          CRC_W         = 16;
    localparam int          BYTE_W        = 8;
    localparam int          ADDR_W        = 16;
    localparam int          BLK_W         = 8;
    localparam logic [7:0]  BLK_LAST      = 8'hff;
    localparam logic [7:0]  BLK_ZERO      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_REQ  = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } scan_state_t;
endpackage

// >>> testbench/checksum_unit_checker.sv
/* checker: port assertions for the checksum unit.
   assumes: bound into every checksum_unit. */
`timescale 1ns/1ps
module checksum_unit_checker (
    input wire logic        clock,     // clk
    input wire logic        srst,      // rst
    input wire logic        init,      // seed load
    input wire logic        seed_ones, // seed pick
    input wire logic        in_valid,  // strobe
    input wire logic        in_ready,  // ready
    input wire logic        rd_req,    // read req
    input wire logic [15:0] rd_addr,   // read addr
    input wire logic        rd_valid,  // read data valid
    input wire logic        busy,      // scanning
    input wire logic        done,      // end pulse
    input wire logic [15:0] result     // crc
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // scan end: one done pulse, then idle
    sequence s_finish; done ##1 (!done && !busy); endsequence
    chk_reset_clear: assert property (disable iff (1'b0) srst |=> result == 16'h0000 && !busy)
        else $error("reset left state");
    chk_seed_load: assert property (init && !busy |=> result == ($past(seed_ones) ? 16'hffff : 16'h0000))
        else $error("bad seed");
    chk_busy_refuse: assert property (busy || init |-> !in_ready) else $error("ready while busy");
    chk_ready_idle: assert property (!busy && !init |-> in_ready) else $error("not ready");
    chk_req_pulse: assert property (rd_req |=> !rd_req && $stable(rd_addr)) else $error("req shape");
    chk_req_busy: assert property (rd_req |-> busy && !done) else $error("req idle");
    chk_done_end: assert property (done |-> s_finish) else $error("done shape");
    chk_result_hold: assert property (!init && !(in_valid && in_ready) && !rd_valid |=> $stable(result))
        else $error("result moved");
endmodule
bind checksum_unit checksum_unit_checker chk (.clock(clock), .srst(srst), .init(init), .seed_ones(seed_ones),
    .in_valid(in_valid), .in_ready(in_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
    .busy(busy), .done(done), .result(result));

// >>> testbench/checksum_unit_tb_top.sv
/* testbench: core stream and flash scan of the checksum unit.
   assumes: flash_model answers reads. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module checksum_unit_tb_top;
    logic clock = 0, srst = 1, init = 0, seed_ones = 0, reverse = 0, in_valid = 0, auto_start = 0, slow = 0;
    logic [7:0] in_data = 8'h00, start_block = 8'h00, block_count = 8'h00, rd_data;
    logic in_ready, rd_req, rd_valid, busy, done;
    logic [15:0] rd_addr, result, exp_r;
    int fail_count = 0, total_checks = 0;
    always #20 clock = ~clock;
    checksum_unit DUT (.clock(clock), .srst(srst), .init(init), .seed_ones(seed_ones), .reverse(reverse),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .auto_start(auto_start),
        .start_block(start_block), .block_count(block_count), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done), .result(result));
    flash_model flash (.clock(clock), .rd_req(rd_req), .rd_addr(rd_addr), .slow(slow), .rd_valid(rd_valid),
        .rd_data(rd_data));
    // reference fold: msb first, no reflection, no final xor
    function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] b);
        if (reverse) b = {<<{b}};
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task seed(input logic ones);
        @(negedge clock);
        init = 1;
        seed_ones = ones;
        #1 `CHK("ready", 1'b0, in_ready)
        @(negedge clock);
        init = 0;
        exp_r = ones ? 16'hffff : 16'h0000;
        `CHK("seed", exp_r, result)
    endtask
    task test_stream;
        for (int m = 0; m < 4; m++) begin
            reverse = m[1];
            seed(m[0]);
            for (int k = 0; k < 4; k++) begin
                in_valid = 1;
                in_data = 8'h5a + 8'h31 * k[7:0];
                exp_r = fold(exp_r, in_data);
                @(negedge clock);
            end
            in_valid = 0;
            `CHK("stream", exp_r, result)
        end
        $display("stream test done");
    endtask
    task test_scan(input logic [7:0] blk, input logic [7:0] cnt, input logic s);
        logic [15:0] ad;
        slow = s;
        reverse = s;
        seed(1'b1);
        start_block = blk;
        block_count = cnt;
        auto_start = 1;
        for (int a = 0; a < 256 * (cnt + 1); a++) begin
            ad = {blk, 8'h00} + a[15:0];
            exp_r = fold(exp_r, ad[7:0] ^ ad[15:8]);
        end
        @(negedge clock);
        auto_start = 0;
        in_valid = 1; // core byte and init must both be refused while scanning
        init = 1;
        start_block = 8'h77;
        `CHK("busy", 1'b1, busy)
        `CHK("refuse", 1'b0, in_ready)
        @(negedge clock);
        init = 0;
        for (int w = 0; w < 5000 && done !== 1'b1; w++) @(negedge clock);
        in_valid = 0;
        `CHK("done", 1'b1, done)
        `CHK("scan", exp_r, result)
        $display("scan test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (12) @(negedge clock);
        srst = 0;
        `CHK("reset", 16'h0000, result)
        test_stream;
        test_scan(8'h02, 8'h00, 1'b0);
        auto_start = 0;
        test_scan(8'h40, 8'h01, 1'b1);
        finish_test;
    end
endmodule

// >>> testbench/flash_model.sv
/* flash read path model: one byte per request, fast or slow.
   assumes: one request outstanding. */
`timescale 1ns/1ps
module flash_model (
    input  wire logic        clock,    // clk
    input  wire logic        rd_req,   // request
    input  wire logic [15:0] rd_addr,  // address
    input  wire logic        slow,     // add wait
    output logic             rd_valid, // strobe
    output logic      [7:0]  rd_data   // byte
);
    logic [1:0] cnt = 2'h0;
    logic       pend = 1'b0;
    initial rd_valid = 1'b0;
    initial rd_data = 8'h00;
    // data toggles when idle so no stale byte looks valid
    always @(posedge clock) begin
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        if (rd_req) begin
            pend <= 1'b1;
            cnt <= slow ? 2'h3 : 2'h0;
        end else if (pend && cnt == 2'h0) begin
            pend <= 1'b0;
            rd_valid <= 1'b1;
            rd_data <= rd_addr[7:0] ^ rd_addr[15:8];
        end else if (pend) begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule
